// ---- verilog/active_area_pkg.sv ----
// constants for the active-area detect register bank
// assumes byte-wide registers reached at their documented offsets
`default_nettype none
package active_area_pkg;

	// register offsets on the control port
	localparam logic [7:0] OFS_REVISION   = 8'h12;
	localparam logic [7:0] OFS_FAMILY     = 8'h13;
	localparam logic [7:0] OFS_EXT_LOW    = 8'h14;
	localparam logic [7:0] OFS_EXT_HIGH   = 8'h15;
	localparam logic [7:0] OFS_HSTART_LO  = 8'h16;
	localparam logic [7:0] OFS_HSTART_HI  = 8'h17;
	localparam logic [7:0] OFS_HEND_LO    = 8'h18;
	localparam logic [7:0] OFS_HEND_HI    = 8'h19;
	localparam logic [7:0] OFS_VSTART_LO  = 8'h1a;
	localparam logic [7:0] OFS_VSTART_HI  = 8'h1b;

	// field positions, extended low register
	localparam int BIT_INTERLACE = 5;
	localparam int BIT_SYNC_POL  = 4;
	localparam int BIT_CLK_POL   = 3;
	localparam int BIT_FREEZE    = 2;
	localparam int BIT_GAIN      = 1;
	localparam int BIT_ZOOM      = 0;

	// field positions, extended high register
	localparam int BIT_V_END_CLR   = 7;
	localparam int BIT_V_START_CLR = 6;
	localparam int BIT_H_END_CLR   = 5;
	localparam int BIT_H_START_CLR = 4;
	localparam int BIT_TALL        = 3;
	localparam int PAT_MSB         = 2;

	// widths
	localparam int REG_W   = 8;
	localparam int COUNT_W = 11;
	localparam int REV_W   = 4;
	localparam int FAM_W   = 7;
	localparam int PIX_W   = 8;

	// reset values
	localparam logic [7:0] EXT_HIGH_RST = 8'h00;
	localparam logic [7:0] READ_NONE    = 8'h00;

	// built-in pattern choices
	typedef enum logic [2:0] {
		PAT_OFF       = 3'h0,
		PAT_ALL_WAVES = 3'h1,
		PAT_BARS_FULL = 3'h2,
		PAT_BARS_75   = 3'h3,
		PAT_CROSS     = 3'h4,
		PAT_RED_RAMP  = 3'h5,
		PAT_GRN_RAMP  = 3'h6,
		PAT_BLU_RAMP  = 3'h7
	} pattern_e;

endpackage : active_area_pkg
`default_nettype wire

// ---- verilog/pin_level_sync.sv ----
// three-stage synchroniser for a level arriving from a pin
// assumes the pin is asynchronous to SYS_CLK
`timescale 1ns/1ps
`default_nettype none
module pin_level_sync (
	input  wire logic clk,
	input  wire logic rst,
	input  wire logic pin_in,
	output var  logic level_out
);

	// all stages of the synchroniser
	typedef struct packed {
		logic s1;   // metastable catch
		logic s2;   // second stage
		logic s3;   // third stage
		logic val;  // accepted level
	} sync_s;

	sync_s st_r;
	sync_s st_nxt;

	////////////////////////////////////////////////////////////////
	// next state: accept a change once stages two and three agree
	always_comb begin
		st_nxt    = st_r;
		st_nxt.s1 = pin_in;
		st_nxt.s2 = st_r.s1;
		st_nxt.s3 = st_r.s2;
		if (st_r.s2 == st_r.s3) begin
			st_nxt.val = st_r.s3;
		end
	end

	// register the state
	always_ff @(posedge clk) begin
		if (rst) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign level_out = st_r.val;

endmodule : pin_level_sync
`default_nettype wire

// ---- verilog/boundary_track.sv ----
// one boundary result: earliest start or latest end since clear
// assumes hit and pos come from the same clock domain
`timescale 1ns/1ps
`default_nettype none
module boundary_track
	import active_area_pkg::*;
#(
	parameter int W        = COUNT_W,
	parameter bit KEEP_MAX = 1'b0
) (
	input  wire logic         clk,
	input  wire logic         rst,
	input  wire logic         clear,
	input  wire logic         hit,
	input  wire logic [W-1:0] pos,
	output var  logic [W-1:0] value,
	output var  logic         valid
);

	// result and its seen flag
	typedef struct packed {
		logic [W-1:0] val;  // stored position
		logic         seen; // a hit since clear
	} track_s;

	track_s st_r;
	track_s st_nxt;
	logic   better;

	////////////////////////////////////////////////////////////////
	// more extreme than stored value
	always_comb begin
		if (KEEP_MAX) begin
			better = pos > st_r.val;
		end else begin
			better = pos < st_r.val;
		end
	end

	// clear holds the result empty, a hit then refines it
	always_comb begin
		st_nxt = st_r;
		if (clear) begin
			st_nxt = '0;
		end else if (hit && (!st_r.seen || better)) begin
			st_nxt.val  = pos;
			st_nxt.seen = 1'b1;
		end
	end

	// register the state
	always_ff @(posedge clk) begin
		if (rst) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign value = st_r.val;
	assign valid = st_r.seen;

	////////////////////////////////////////////////////////////////
	// a less extreme hit leaves the result untouched
	chk_keep_extreme: assert property (
		@(posedge clk) disable iff (rst)
		(!clear && st_r.seen && hit && !better) |=> $stable(st_r.val))
		else $error("boundary result moved on a less extreme hit");

	// first hit after clear is taken as is
	chk_first_hit: assert property (
		@(posedge clk) disable iff (rst)
		(!clear && !st_r.seen && hit) |=> (valid && value == $past(pos)))
		else $error("first hit after clear not stored");

endmodule : boundary_track
`default_nettype wire

// ---- verilog/active_area_regs.sv ----
// register bank: identity, extended command and active-area results
// assumes a decoded byte port from the serial control interface and
// video timing strobes synchronous to SYS_CLK, one sample per clock
`timescale 1ns/1ps
`default_nettype none

module active_area_regs
	import active_area_pkg::*;
#(
	parameter logic [REV_W-1:0] REVISION_CODE = 4'h5,  // arbitrary value
	parameter logic [FAM_W-1:0] FAMILY_CODE   = 7'h2a  // arbitrary value
) (
	input  wire logic               SYS_CLK,
	input  wire logic               RST,
	input  wire logic [REG_W-1:0]   REG_ADDR,
	input  wire logic [REG_W-1:0]   REG_WDATA,
	input  wire logic               REG_WR,
	input  wire logic               REG_RD,
	output var  logic [REG_W-1:0]   REG_RDATA,
	input  wire logic               SYNC_POL_PIN,
	input  wire logic               CLK_POL_PIN,
	input  wire logic               LINE_START,
	input  wire logic               FRAME_START,
	input  wire logic               SAMPLE_VALID,
	input  wire logic [PIX_W-1:0]   RED_IN,
	input  wire logic [PIX_W-1:0]   GREEN_IN,
	input  wire logic [PIX_W-1:0]   BLUE_IN,
	input  wire logic [PIX_W-1:0]   BLANK_THRESHOLD,
	output var  logic               INTERLACE_DETECT_EN,
	output var  logic               FREEZE_FRAME,
	output var  logic               INPUT_GAIN_SELECT,
	output var  logic               ZOOM_EN,
	output var  logic               FLICKER_SHARP_OFF,
	output var  logic               PATTERN_TALL_SIZE,
	output var  logic [PAT_MSB:0]   PATTERN_SELECT,
	output var  logic [COUNT_W-1:0] ACTIVE_V_END_COUNT
);

	////////////////////////////////////////////////////////////////
	// state of the bank
	typedef struct packed {
		logic               interlace;  // interlace detect enable
		logic               freeze;     // freeze frame
		logic               gain;       // input gain select
		logic               zoom;       // zoom on
		logic               filter_off; // flicker and sharpness off
		logic [REG_W-1:0]   ext_high;   // clears, size, pattern
		logic [REG_W-1:0]   rdata;      // read return byte
		logic [COUNT_W-1:0] h_pos;      // clocks since line start
		logic [COUNT_W-1:0] v_pos;      // lines since frame start
	} bank_s;

	bank_s st_r;
	bank_s st_nxt;

	// synchronised polarity levels
	logic                sync_pol;       // sync edge polarity
	logic                clk_pol;        // pixel clock edge polarity
	// detection
	logic                hit;            // sample counts as active
	// boundary results
	logic [COUNT_W-1:0]  h_start_val;    // earliest horizontal
	logic [COUNT_W-1:0]  h_end_val;      // latest horizontal
	logic [COUNT_W-1:0]  v_start_val;    // earliest vertical
	logic [COUNT_W-1:0]  v_end_val;      // latest vertical
	logic                h_start_seen;   // horizontal start valid
	logic                v_end_seen;     // vertical end valid

	////////////////////////////////////////////////////////////////
	// low byte of an 11-bit count
	function automatic logic [REG_W-1:0] cnt_low(input logic [COUNT_W-1:0] c);
		cnt_low = c[REG_W-1:0];
	endfunction : cnt_low

	// high byte of an 11-bit count, unused bits zero
	function automatic logic [REG_W-1:0] cnt_high(input logic [COUNT_W-1:0] c);
		cnt_high = {{(2*REG_W-COUNT_W){1'b0}}, c[COUNT_W-1:REG_W]};
	endfunction : cnt_high

	////////////////////////////////////////////////////////////////
	// polarity pins enter through synchronisers
	pin_level_sync u_sync_pol (
		.clk       (SYS_CLK),
		.rst       (RST),
		.pin_in    (SYNC_POL_PIN),
		.level_out (sync_pol)
	);

	pin_level_sync u_clk_pol (
		.clk       (SYS_CLK),
		.rst       (RST),
		.pin_in    (CLK_POL_PIN),
		.level_out (clk_pol)
	);

	////////////////////////////////////////////////////////////////
	// active when any channel reaches the threshold
	always_comb begin
		hit = SAMPLE_VALID &&
		      ((RED_IN >= BLANK_THRESHOLD) ||
		       (GREEN_IN >= BLANK_THRESHOLD) ||
		       (BLUE_IN >= BLANK_THRESHOLD));
	end

	////////////////////////////////////////////////////////////////
	// four boundary trackers
	boundary_track #(
		.W        (COUNT_W),
		.KEEP_MAX (1'b0)
	) u_h_start (
		.clk   (SYS_CLK),
		.rst   (RST),
		.clear (st_r.ext_high[BIT_H_START_CLR]),
		.hit   (hit),
		.pos   (st_r.h_pos),
		.value (h_start_val),
		.valid (h_start_seen)
	);

	boundary_track #(
		.W        (COUNT_W),
		.KEEP_MAX (1'b1)
	) u_h_end (
		.clk   (SYS_CLK),
		.rst   (RST),
		.clear (st_r.ext_high[BIT_H_END_CLR]),
		.hit   (hit),
		.pos   (st_r.h_pos),
		.value (h_end_val),
		.valid ()
	);

	boundary_track #(
		.W        (COUNT_W),
		.KEEP_MAX (1'b0)
	) u_v_start (
		.clk   (SYS_CLK),
		.rst   (RST),
		.clear (st_r.ext_high[BIT_V_START_CLR]),
		.hit   (hit),
		.pos   (st_r.v_pos),
		.value (v_start_val),
		.valid ()
	);

	boundary_track #(
		.W        (COUNT_W),
		.KEEP_MAX (1'b1)
	) u_v_end (
		.clk   (SYS_CLK),
		.rst   (RST),
		.clear (st_r.ext_high[BIT_V_END_CLR]),
		.hit   (hit),
		.pos   (st_r.v_pos),
		.value (v_end_val),
		.valid (v_end_seen)
	);

	////////////////////////////////////////////////////////////////
	// next state: position counters, writes and read return
	always_comb begin
		st_nxt = st_r;

		// horizontal position, saturates at full scale
		if (LINE_START) begin
			st_nxt.h_pos = '0;
		end else if (st_r.h_pos != {COUNT_W{1'b1}}) begin
			st_nxt.h_pos = COUNT_W'(st_r.h_pos + 1'b1);
		end

		// vertical position, frame start wins over line start
		if (FRAME_START) begin
			st_nxt.v_pos = '0;
		end else if (LINE_START && (st_r.v_pos != {COUNT_W{1'b1}})) begin
			st_nxt.v_pos = COUNT_W'(st_r.v_pos + 1'b1);
		end

		// register writes, read-only offsets ignore them
		if (REG_WR) begin
			unique case (REG_ADDR)
				OFS_EXT_LOW: begin
					st_nxt.interlace = REG_WDATA[BIT_INTERLACE];
					st_nxt.freeze    = REG_WDATA[BIT_FREEZE];
					st_nxt.gain      = REG_WDATA[BIT_GAIN];
					st_nxt.zoom      = REG_WDATA[BIT_ZOOM];
					st_nxt.filter_off = REG_WDATA[BIT_ZOOM];
				end
				OFS_EXT_HIGH: begin
					st_nxt.ext_high = REG_WDATA;
				end
				default: begin
					// nothing writable here
				end
			endcase
		end

		// read return, unmapped offsets answer zero
		if (REG_RD) begin
			unique case (REG_ADDR)
				OFS_REVISION:  st_nxt.rdata = {{(REG_W-REV_W){1'b0}}, REVISION_CODE};
				OFS_FAMILY:    st_nxt.rdata = {{(REG_W-FAM_W){1'b0}}, FAMILY_CODE};
				OFS_EXT_LOW: begin
					st_nxt.rdata                = READ_NONE;
					st_nxt.rdata[BIT_INTERLACE] = st_r.interlace;
					st_nxt.rdata[BIT_SYNC_POL]  = sync_pol;
					st_nxt.rdata[BIT_CLK_POL]   = clk_pol;
					st_nxt.rdata[BIT_FREEZE]    = st_r.freeze;
					st_nxt.rdata[BIT_GAIN]      = st_r.gain;
					st_nxt.rdata[BIT_ZOOM]      = st_r.zoom;
				end
				OFS_EXT_HIGH:  st_nxt.rdata = st_r.ext_high;
				OFS_HSTART_LO: st_nxt.rdata = cnt_low(h_start_val);
				OFS_HSTART_HI: st_nxt.rdata = cnt_high(h_start_val);
				OFS_HEND_LO:   st_nxt.rdata = cnt_low(h_end_val);
				OFS_HEND_HI:   st_nxt.rdata = cnt_high(h_end_val);
				OFS_VSTART_LO: st_nxt.rdata = cnt_low(v_start_val);
				OFS_VSTART_HI: st_nxt.rdata = cnt_high(v_start_val);
				default:       st_nxt.rdata = READ_NONE;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////
	// register the state
	always_ff @(posedge SYS_CLK) begin
		if (RST) begin
			st_r          <= '0;
			st_r.ext_high <= EXT_HIGH_RST;
			st_r.rdata    <= READ_NONE;
		end else begin
			st_r <= st_nxt;
		end
	end

	////////////////////////////////////////////////////////////////
	// outputs straight from flops
	assign REG_RDATA           = st_r.rdata;
	assign INTERLACE_DETECT_EN = st_r.interlace;
	assign FREEZE_FRAME        = st_r.freeze;
	assign INPUT_GAIN_SELECT   = st_r.gain;
	assign ZOOM_EN             = st_r.zoom;
	assign FLICKER_SHARP_OFF   = st_r.filter_off;
	assign PATTERN_TALL_SIZE   = st_r.ext_high[BIT_TALL];
	assign PATTERN_SELECT      = st_r.ext_high[PAT_MSB:0];
	assign ACTIVE_V_END_COUNT  = v_end_val;

	////////////////////////////////////////////////////////////////
	// checks
	chk_revision_read: assert property (
		@(posedge SYS_CLK) disable iff (RST)
		(REG_RD && REG_ADDR == OFS_REVISION) |=>
			(REG_RDATA == {{(REG_W-REV_W){1'b0}}, REVISION_CODE}))
		else $error("revision byte wrong");

	chk_family_read: assert property (
		@(posedge SYS_CLK) disable iff (RST)
		(REG_RD && REG_ADDR == OFS_FAMILY) |=> (REG_RDATA[FAM_W-1:0] == FAMILY_CODE
			&& !REG_RDATA[REG_W-1]))
		else $error("family byte wrong");

	chk_interlace_write: assert property (
		@(posedge SYS_CLK) disable iff (RST)
		(REG_WR && REG_ADDR == OFS_EXT_LOW) |=>
			(INTERLACE_DETECT_EN == $past(REG_WDATA[BIT_INTERLACE])))
		else $error("interlace enable not written");

	chk_sync_pol_read: assert property (
		@(posedge SYS_CLK) disable iff (RST)
		(REG_RD && REG_ADDR == OFS_EXT_LOW) |=> (REG_RDATA[BIT_SYNC_POL] == $past(sync_pol)))
		else $error("sync polarity read wrong");

	chk_clk_pol_read: assert property (
		@(posedge SYS_CLK) disable iff (RST)
		(REG_RD && REG_ADDR == OFS_EXT_LOW) |=> (REG_RDATA[BIT_CLK_POL] == $past(clk_pol)))
		else $error("clock polarity read wrong");

	chk_freeze_gain: assert property (
		@(posedge SYS_CLK) disable iff (RST)
		(REG_WR && REG_ADDR == OFS_EXT_LOW) |=>
			(FREEZE_FRAME == $past(REG_WDATA[BIT_FREEZE])
			&& INPUT_GAIN_SELECT == $past(REG_WDATA[BIT_GAIN])))
		else $error("freeze or gain not written");

	chk_zoom_disables: assert property (
		@(posedge SYS_CLK) disable iff (RST)
		ZOOM_EN |-> FLICKER_SHARP_OFF)
		else $error("zoom on but flicker and sharpness active");

	chk_clear_restart: assert property (
		@(posedge SYS_CLK) disable iff (RST)
		(REG_WR && REG_ADDR == OFS_EXT_HIGH && REG_WDATA[BIT_H_START_CLR]) |=>
			##1 (!h_start_seen && h_start_val == '0))
		else $error("horizontal start not cleared");

	chk_pattern_write: assert property (
		@(posedge SYS_CLK) disable iff (RST)
		(REG_WR && REG_ADDR == OFS_EXT_HIGH) |=>
			(PATTERN_SELECT == $past(REG_WDATA[PAT_MSB:0])
			&& PATTERN_TALL_SIZE == $past(REG_WDATA[BIT_TALL])))
		else $error("pattern fields not written");

	chk_hstart_read: assert property (
		@(posedge SYS_CLK) disable iff (RST)
		(REG_RD && REG_ADDR == OFS_HSTART_LO) |=> (REG_RDATA == $past(h_start_val[REG_W-1:0])))
		else $error("horizontal start low byte wrong");

	chk_below_threshold: assert property (
		@(posedge SYS_CLK) disable iff (RST)
		(!hit && !st_r.ext_high[BIT_V_END_CLR]) |=> $stable(v_end_val))
		else $error("vertical end moved without active sample");

	chk_vend_grows: assert property (
		@(posedge SYS_CLK) disable iff (RST)
		(v_end_seen && !st_r.ext_high[BIT_V_END_CLR]) |=> (v_end_val >= $past(v_end_val)))
		else $error("vertical end shrank without clear");

	// low byte of the latest horizontal position
	chk_hend_read: assert property (
		@(posedge SYS_CLK) disable iff (RST)
		(REG_RD && REG_ADDR == OFS_HEND_LO) |=> (REG_RDATA == $past(h_end_val[REG_W-1:0])))
		else $error("horizontal end low byte wrong");

	// high byte carries the top count bits under a zero pad
	chk_vstart_high: assert property (
		@(posedge SYS_CLK) disable iff (RST)
		(REG_RD && REG_ADDR == OFS_VSTART_HI) |=>
			(REG_RDATA[REG_W-1:COUNT_W-REG_W] == '0
			&& REG_RDATA[COUNT_W-REG_W-1:0] == $past(v_start_val[COUNT_W-1:REG_W])))
		else $error("vertical start high byte wrong");

	// a sample below threshold on every channel never counts
	chk_blank_sample: assert property (
		@(posedge SYS_CLK) disable iff (RST)
		(RED_IN < BLANK_THRESHOLD && GREEN_IN < BLANK_THRESHOLD
			&& BLUE_IN < BLANK_THRESHOLD) |-> !hit)
		else $error("blank sample taken as active");

endmodule : active_area_regs
`default_nettype wire

// ---- testbench/host_port_model.sv ----
// host side of the register byte port: write and read tasks
// assumes the bank takes a strobe on the rising edge of clk
`timescale 1ns/1ps
`default_nettype none
module host_port_model
	import active_area_pkg::*;
(
	input  wire logic             clk,
	output var  logic [REG_W-1:0] addr,
	output var  logic [REG_W-1:0] wdata,
	output var  logic             wr,
	output var  logic             rd,
	input  wire logic [REG_W-1:0] rdata
);
	// port idle with strobes low at time zero
	initial begin
		addr = 8'h00;
		wdata = 8'h00;
		wr = 1'b0;
		rd = 1'b0;
	end

	////////////////////////////////////////////////////////////////////
	// one-cycle write strobe; released bus shows inverted values
	task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		addr  <= a;
		wdata <= d;
		wr    <= 1'b1;
		@(posedge clk);
		wr    <= 1'b0;
		addr  <= ~a;
		wdata <= ~d;
	endtask : write_reg

	// one-cycle read strobe, data taken once it has landed
	task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
		@(posedge clk);
		addr <= a;
		rd   <= 1'b1;
		@(posedge clk);
		rd   <= 1'b0;
		addr <= ~a;
		@(posedge clk);
		#1 d = rdata;
	endtask : read_reg
endmodule : host_port_model
`default_nettype wire

// ---- testbench/tb_top.sv ----
// self-checking bench for the active-area register bank
// assumes the host model drives the register port, bench drives video
`timescale 1ns/1ps
`default_nettype none
module tb_top
	import active_area_pkg::*;
;

	localparam logic [3:0] REV = 4'h9;   // arbitrary value
	localparam logic [6:0] FAM = 7'h3c;  // arbitrary value
	localparam logic [7:0] THR = 8'h40;  // active threshold

	logic        sys_clk = 1'b0;
	logic        rst = 1'b1;
	logic [7:0]  reg_addr, reg_wdata, reg_rdata;
	logic        reg_wr, reg_rd;
	logic        sync_pin = 1'b1;
	logic        clk_pin = 1'b0;
	logic        line_start = 1'b0;
	logic        frame_start = 1'b0;
	logic        sample_valid = 1'b0;
	logic [7:0]  pix = 8'h00;
	logic        interlace, freeze, gain, zoom, filter_off, tall;
	logic [7:0]  thr = THR;        // threshold fed to the bank
	logic [2:0]  pat;
	logic [10:0] v_end;
	int          fails = 0;
	int          check_count = 0;
	logic [7:0]  b;
	logic [10:0] w;

	// 100 MHz clock
	always #5 sys_clk = ~sys_clk;

	host_port_model host_port_model_inst (
		.clk(sys_clk), .addr(reg_addr), .wdata(reg_wdata),
		.wr(reg_wr), .rd(reg_rd), .rdata(reg_rdata)
	);

	active_area_regs #(.REVISION_CODE(REV), .FAMILY_CODE(FAM)) active_area_regs_inst (
		.SYS_CLK(sys_clk), .RST(rst), .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata),
		.REG_WR(reg_wr), .REG_RD(reg_rd), .REG_RDATA(reg_rdata),
		.SYNC_POL_PIN(sync_pin), .CLK_POL_PIN(clk_pin), .LINE_START(line_start),
		.FRAME_START(frame_start), .SAMPLE_VALID(sample_valid), .RED_IN(pix),
		.GREEN_IN(pix), .BLUE_IN(pix), .BLANK_THRESHOLD(thr),
		.INTERLACE_DETECT_EN(interlace), .FREEZE_FRAME(freeze),
		.INPUT_GAIN_SELECT(gain), .ZOOM_EN(zoom), .FLICKER_SHARP_OFF(filter_off),
		.PATTERN_TALL_SIZE(tall), .PATTERN_SELECT(pat), .ACTIVE_V_END_COUNT(v_end)
	);

	////////////////////////////////////////////////////////////////////
	// compare and count
	task automatic check(input string nm, input logic [15:0] e, input logic [15:0] g);
		check_count++;
		if (g !== e) begin
			$display("[ERR] %s expected %h seen %h", nm, e, g);
			fails++;
		end
	endtask : check

	// read an 11-bit count, low byte then high byte
	task automatic rd16(input logic [7:0] a, output logic [10:0] v);
		logic [7:0] lo, hi;
		host_port_model_inst.read_reg(a, lo);
		host_port_model_inst.read_reg(a + 8'h01, hi);
		check("count high pad", 16'h0000, {11'h000, hi[7:3]});
		v = {hi[2:0], lo};
	endtask : rd16

	// one line of 16 samples; f also marks frame start
	task automatic line(input int p0, input int p1, input int p2, input bit f);
		@(posedge sys_clk);
		line_start  <= 1'b1;
		frame_start <= f;
		for (int i = 0; i < 16; i++) begin
			@(posedge sys_clk);
			line_start   <= 1'b0;
			frame_start  <= 1'b0;
			sample_valid <= 1'b1;
			pix <= (i == p0 || i == p2) ? THR + 8'h40 : (i == p1) ? THR : THR - 8'h01;
		end
		@(posedge sys_clk);
		sample_valid <= 1'b0;
		pix <= 8'h00;
	endtask : line

	// verdict
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", check_count, fails);
		if (fails == 0 && check_count > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : end_of_test

	// watchdog against a hang
	initial begin
		repeat (20000) @(posedge sys_clk);
		fails++;
		end_of_test();
	end

	////////////////////////////////////////////////////////////////////
	// main sequence
	initial begin
		repeat (3) @(posedge sys_clk);
		rst <= 1'b0;
		repeat (6) @(posedge sys_clk);
		check("ctl after reset", 16'h0000, {zoom, freeze, gain, interlace, tall, pat});
		host_port_model_inst.read_reg(OFS_REVISION, b);
		check("revision", {8'h00, 4'h0, REV}, {8'h00, b});
		host_port_model_inst.write_reg(OFS_REVISION, 8'hff);
		host_port_model_inst.read_reg(OFS_FAMILY, b);
		check("family", {9'h000, FAM}, {8'h00, b});
		host_port_model_inst.read_reg(OFS_REVISION, b);
		check("revision ro", {12'h000, REV}, {8'h00, b});
		host_port_model_inst.read_reg(8'h40, b);
		check("unmapped", 16'h0000, {8'h00, b});
		// all writable low bits set, polarity bits from pins
		host_port_model_inst.write_reg(OFS_EXT_LOW, 8'hff);
		host_port_model_inst.read_reg(OFS_EXT_LOW, b);
		check("ext low", 16'h0037, {8'h00, b});
		check("ctl out", 16'h001f, {interlace, freeze, gain, zoom, filter_off});
		@(posedge sys_clk);
		sync_pin <= 1'b0;
		clk_pin  <= 1'b1;
		host_port_model_inst.write_reg(OFS_EXT_LOW, 8'h00);
		repeat (6) @(posedge sys_clk);
		host_port_model_inst.read_reg(OFS_EXT_LOW, b);
		check("ext low pol", 16'h0008, {8'h00, b});
		check("ctl off", 16'h0000, {interlace, freeze, gain, zoom, filter_off});
		// every pattern code, tall size toggled alongside
		for (int p = 0; p < 8; p++) begin
			host_port_model_inst.write_reg(OFS_EXT_HIGH, {4'h0, p[0], p[2:0]});
			host_port_model_inst.read_reg(OFS_EXT_HIGH, b);
			check("ext high", {8'h00, 4'h0, p[0], p[2:0]}, {8'h00, b});
			check("pattern out", {12'h000, p[0], p[2:0]}, {12'h000, tall, pat});
		end
		host_port_model_inst.write_reg(OFS_EXT_HIGH, 8'h00);
		// frame: idle line 0, active lines 1..3
		line(-1, -1, -1, 1'b1);
		line(5, -1, 9, 1'b0);
		line(3, -1, 7, 1'b0);
		line(12, 2, -1, 1'b0);
		host_port_model_inst.write_reg(OFS_HSTART_LO, 8'h55);
		rd16(OFS_HSTART_LO, w);
		check("h start", 16'd2, {5'h00, w});
		rd16(OFS_HEND_LO, w);
		check("h end", 16'd12, {5'h00, w});
		rd16(OFS_VSTART_LO, w);
		check("v start", 16'd1, {5'h00, w});
		check("v end", 16'd3, {5'h00, v_end});
		// clear all four results and hold them clear
		host_port_model_inst.write_reg(OFS_EXT_HIGH, 8'hf0);
		line(-1, -1, 4, 1'b1);
		rd16(OFS_HSTART_LO, w);
		check("h start clr", 16'd0, {5'h00, w});
		rd16(OFS_HEND_LO, w);
		check("h end clr", 16'd0, {5'h00, w});
		rd16(OFS_VSTART_LO, w);
		check("v start clr", 16'd0, {5'h00, w});
		check("v end clr", 16'd0, {5'h00, v_end});
		// redetect on a fresh frame
		host_port_model_inst.write_reg(OFS_EXT_HIGH, 8'h00);
		line(-1, -1, -1, 1'b1);
		line(-1, -1, -1, 1'b0);
		line(6, -1, 8, 1'b0);
		rd16(OFS_HSTART_LO, w);
		check("h start new", 16'd6, {5'h00, w});
		rd16(OFS_HEND_LO, w);
		check("h end new", 16'd8, {5'h00, w});
		rd16(OFS_VSTART_LO, w);
		check("v start new", 16'd2, {5'h00, w});
		check("v end new", 16'd2, {5'h00, v_end});
		// a raised threshold makes the same bright sample blank
		host_port_model_inst.write_reg(OFS_EXT_HIGH, 8'h10);
		host_port_model_inst.write_reg(OFS_EXT_HIGH, 8'h00);
		thr <= THR + 8'h41;
		line(3, -1, -1, 1'b1);
		rd16(OFS_HSTART_LO, w);
		check("h start thr", 16'd0, {5'h00, w});
		rd16(OFS_HEND_LO, w);
		check("h end kept", 16'd8, {5'h00, w});
		end_of_test();
	end
endmodule : tb_top
`default_nettype wire
